/* spx_cfg.svh */
// constants of the serial command port: opcodes, map, fifo and bit layout
`ifndef SPX_CFG_SVH
`define SPX_CFG_SVH

// ----------------------------------------------------------------
// operation decode
// ----------------------------------------------------------------
`define SPX_MODE_WRITE 2'b00
`define SPX_MODE_READ 2'b01
`define SPX_MODE_FIFO 2'b10
`define SPX_MODE_CMD 2'b11
`define SPX_TRAIL_FLOAD 6'h00
`define SPX_TRAIL_FREAD 6'h3f
`define SPX_LAST_BIT 3'd7

// ----------------------------------------------------------------
// register map and control fields
// ----------------------------------------------------------------
`define SPX_RW_TOP 6'h2f
`define SPX_STAT_ADDR 6'h3f
`define SPX_IOCFG2_ADDR 6'h01
`define SPX_PDA_BIT 4
`define SPX_PDB_BIT 3
`define SPX_OPCTL_ADDR 6'h02
`define SPX_EN_BIT 7
`define SPX_LONG_CMD_MIN 6'h38

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
`define SPX_FIFO_DEPTH 7'd96
`define SPX_FIFO_LAST 7'd95

`endif

/* spx_evt_sync.sv */
// toggle event crossing from the serial clock into the core clock
`timescale 1ns/1ps
`default_nettype none
module spx_evt_sync
  import spx_pkg::*;
(
  // core clock and reset
  input wire logic mclk,
  input wire logic rst,
  // toggle from the link side
  input wire logic tgl,
  // one-cycle pulse per toggle
  output logic pulse
);

  spx_evt_t s_q;
  spx_evt_t s_d;

  // s1 feeds only s2; the edge compare looks at s2 and s3
  always_comb begin
    s_d = s_q;
    s_d.s1 = tgl;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.pulse = s_q.s2 ^ s_q.s3;
  end

  // sync reset on the core clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;

endmodule
`default_nettype wire

/* spx_master.sv */
// serial master model for the far side of the command port
`timescale 1ns/1ps
`default_nettype none
module spx_master (
  // link pins
  output logic sclk,
  output logic ss_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_pd_en
);
  logic last_q;
  logic line;
  // a floating line shows the pull-down or an inverted ghost value
  assign line = sdo_oe ? sdo : (sdo_pd_en ? 1'b0 : ~last_q);
  // idle: deselected, clock still
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    sdi = 1'b0;
    last_q = 1'b0;
  end
  // select and wait past the select-to-clock setup
  task automatic sel();
    ss_n = 1'b0;
    #30;
  endtask
  // keep the last fall clear of the rise, then rest deselected
  task automatic desel();
    #310;
    ss_n = 1'b1;
    #150;
  endtask
  // n bits of a byte; the gap lets strobes cross to the core clock
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    // data moves mid-low so no falling edge ever sees it change
    for (int i = 7; i > 7 - n; i--) begin
      #3 sdi = tx[i];
      #3 sclk = 1'b1;
      #6 rx = {rx[6:0], line};
      last_q = line;
      sclk = 1'b0;
    end
    #250;
  endtask
endmodule
`default_nettype wire

/* spx_pkg.sv */
// types shared by the serial command port and its event crossing
package spx_pkg;

  // decode phase inside one chip-select period
  typedef enum logic [2:0] {
    PH_MODE, PH_WRITE, PH_READ, PH_FLOAD, PH_FREAD, PH_IGNORE
  } spx_phase_t;

  // per-frame state, cleared whenever chip select is high
  typedef struct packed {
    spx_phase_t phase;
    logic [2:0] bit_cnt;
    logic [6:0] shreg;
    logic [5:0] addr;
    logic ok_s1;
    logic ok_s2;
  } spx_frame_t;

  // link-side state that must survive between frames
  typedef struct packed {
    logic [6:0] wp;
    logic [6:0] rp;
    logic [6:0] count;
    logic wr_tgl;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic cmd_tgl;
    logic [5:0] cmd_code;
    logic push_tgl;
    logic [7:0] push_data;
  } spx_keep_t;

  // serial output stage
  typedef struct packed {
    logic sdo;
    logic oe;
    logic [6:0] tx;
  } spx_tx_t;

  // core clock side
  typedef struct packed {
    logic ssn_s1;
    logic ssn_s2;
    logic ssn_s3;
    logic oe_s1;
    logic oe_s2;
    logic en;
    logic pda;
    logic pdb;
    logic busy;
    logic irq;
    logic fifo_ok;
    logic pd_en;
    logic reg_wr_stb;
    logic [5:0] reg_wr_addr;
    logic [7:0] reg_wr_data;
    logic cmd_stb;
    logic [5:0] cmd_code;
    logic push_stb;
    logic [7:0] push_data;
  } spx_core_t;

  // toggle-to-pulse crossing
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } spx_evt_t;

endpackage

/* spx_port.sv */
// serial command port: mode decode, registers, fifo, direct commands
`timescale 1ns/1ps
`default_nettype none
`include "spx_cfg.svh"
module spx_port
  import spx_pkg::*;
(
  // core clock domain
  input wire logic mclk,
  input wire logic rst,
  // serial link pins
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic sdo_pd_en,
  // chip status in
  input wire logic osc_stable,
  input wire logic proc_done,
  // interrupt request to the master
  output logic irq,
  // register writes toward the chip
  output logic reg_wr_stb,
  output logic [5:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  // direct commands toward the chip
  output logic cmd_stb,
  output logic [5:0] cmd_code,
  // loaded fifo bytes toward the framer
  output logic fifo_push_stb,
  output logic [7:0] fifo_push_data
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0] regs [0:63];
  logic [7:0] fifo [0:95];

  spx_frame_t f_q;
  spx_frame_t f_d;
  spx_keep_t k_q;
  spx_keep_t k_d;
  spx_tx_t t_q;
  spx_tx_t t_d;
  spx_core_t c_q;
  spx_core_t c_d;

  logic rst_s1;
  logic rst_s2;
  logic reg_we;
  logic fifo_we;
  logic [7:0] byte_in;
  logic [7:0] tx_byte;
  logic wr_pulse;
  logic cmd_pulse;
  logic push_pulse;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // writable space; the status word above it is read-only
  function automatic logic writable(input logic [5:0] a);
    writable = (a <= `SPX_RW_TOP);
  endfunction

  // fifo pointer wraps at the last slot of the 96-byte store
  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    if (p == `SPX_FIFO_LAST) begin
      next_ptr = 7'h00;
    end else begin
      next_ptr = p + 7'h01;
    end
  endfunction

  // commands at the top of the code space run for a long time
  function automatic logic is_long(input logic [5:0] code);
    is_long = (code >= `SPX_LONG_CMD_MIN);
  endfunction

  // ----------------------------------------------------------------
  // link side: receive on the falling serial clock edge
  // ----------------------------------------------------------------

  // decode each byte as its eighth bit arrives
  always_comb begin
    f_d = f_q;
    k_d = k_q;
    reg_we = 1'b0;
    fifo_we = 1'b0;
    byte_in = {f_q.shreg, sdi};
    f_d.ok_s1 = c_q.fifo_ok;
    f_d.ok_s2 = f_q.ok_s1;
    f_d.shreg = {f_q.shreg[5:0], sdi};
    f_d.bit_cnt = f_q.bit_cnt + 3'd1;
    if (f_q.bit_cnt == `SPX_LAST_BIT) begin
      case (f_q.phase)
        PH_MODE: begin
          f_d.addr = byte_in[5:0];
          case (byte_in[7:6])
            `SPX_MODE_WRITE: begin
              f_d.phase = PH_WRITE;
            end
            `SPX_MODE_READ: begin
              f_d.phase = PH_READ;
            end
            `SPX_MODE_FIFO: begin
              // fifo traffic only with enable and a stable oscillator
              if (!f_q.ok_s2) begin
                f_d.phase = PH_IGNORE;
              end else if (byte_in[5:0] == `SPX_TRAIL_FLOAD) begin
                f_d.phase = PH_FLOAD;
              end else if (byte_in[5:0] == `SPX_TRAIL_FREAD) begin
                f_d.phase = PH_FREAD;
              end else begin
                f_d.phase = PH_IGNORE;
              end
            end
            default: begin
              // direct command fires now; next byte is a new mode byte
              k_d.cmd_tgl = ~k_q.cmd_tgl;
              k_d.cmd_code = byte_in[5:0];
              f_d.phase = PH_MODE;
            end
          endcase
        end
        PH_WRITE: begin
          if (writable(f_q.addr)) begin
            reg_we = 1'b1;
            k_d.wr_tgl = ~k_q.wr_tgl;
            k_d.wr_addr = f_q.addr;
            k_d.wr_data = byte_in;
          end
          f_d.addr = f_q.addr + 6'd1;
        end
        PH_READ: begin
          f_d.addr = f_q.addr + 6'd1;
        end
        PH_FLOAD: begin
          // a full fifo drops the byte rather than overwrite
          if (k_q.count != `SPX_FIFO_DEPTH) begin
            fifo_we = 1'b1;
            k_d.wp = next_ptr(k_q.wp);
            k_d.count = k_q.count + 7'd1;
            k_d.push_tgl = ~k_q.push_tgl;
            k_d.push_data = byte_in;
          end
        end
        PH_FREAD: begin
          // pop only once all eight bits have gone out
          if (k_q.count != 7'd0) begin
            k_d.rp = next_ptr(k_q.rp);
            k_d.count = k_q.count - 7'd1;
          end
        end
        default: begin
          f_d.phase = f_q.phase;
        end
      endcase
    end
    // fifo phases never fall back to mode decode inside a frame
    if (f_q.phase == PH_FLOAD || f_q.phase == PH_FREAD) begin
      f_d.phase = f_q.phase;
    end
  end

  // frame state: chip select high holds it in reset
  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // core reset brought onto the serial clock; s1 feeds only s2
  always_ff @(negedge sclk) begin
    rst_s1 <= rst;
    rst_s2 <= rst_s1;
  end

  // persistent link state: a partial byte never reaches here
  always_ff @(negedge sclk) begin
    if (rst_s2) begin
      k_q <= '0;
    end else if (!ss_n) begin
      k_q <= k_d;
    end
  end

  // register and fifo storage written on the eighth falling edge
  always_ff @(negedge sclk) begin
    if (reg_we && !ss_n) begin
      regs[f_q.addr] <= byte_in;
    end
    if (fifo_we && !ss_n) begin
      fifo[k_q.wp] <= byte_in;
    end
  end

  // ----------------------------------------------------------------
  // link side: transmit on the rising serial clock edge
  // ----------------------------------------------------------------

  // word to send: register, status, fifo head or zero
  always_comb begin
    tx_byte = 8'h00;
    if (f_q.phase == PH_FREAD) begin
      if (k_q.count != 7'd0) begin
        tx_byte = fifo[k_q.rp];
      end
    end else if (writable(f_q.addr)) begin
      tx_byte = regs[f_q.addr];
    end else if (f_q.addr == `SPX_STAT_ADDR) begin
      tx_byte = {1'b0, k_q.count};
    end
  end

  // load a new byte at each byte start in a read phase
  always_comb begin
    t_d = t_q;
    if (f_q.bit_cnt == 3'd0 &&
        (f_q.phase == PH_READ || f_q.phase == PH_FREAD)) begin
      t_d.sdo = tx_byte[7];
      t_d.tx = tx_byte[6:0];
      t_d.oe = 1'b1;
    end else begin
      t_d.sdo = t_q.tx[6];
      t_d.tx = {t_q.tx[5:0], 1'b0};
    end
  end

  // output floats from deselect until read data starts
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  // ----------------------------------------------------------------
  // crossings into the core clock
  // ----------------------------------------------------------------

  // payload words sit still for a whole byte time after each toggle
  spx_evt_sync u_wr_sync (
    .mclk(mclk),
    .rst(rst),
    .tgl(k_q.wr_tgl),
    .pulse(wr_pulse)
  );

  spx_evt_sync u_cmd_sync (
    .mclk(mclk),
    .rst(rst),
    .tgl(k_q.cmd_tgl),
    .pulse(cmd_pulse)
  );

  spx_evt_sync u_push_sync (
    .mclk(mclk),
    .rst(rst),
    .tgl(k_q.push_tgl),
    .pulse(push_pulse)
  );

  // ----------------------------------------------------------------
  // core side
  // ----------------------------------------------------------------

  // shadows, strobes, pull-down and interrupt
  always_comb begin
    c_d = c_q;
    c_d.ssn_s1 = ss_n;
    c_d.ssn_s2 = c_q.ssn_s1;
    c_d.ssn_s3 = c_q.ssn_s2;
    c_d.oe_s1 = t_q.oe;
    c_d.oe_s2 = c_q.oe_s1;
    c_d.reg_wr_stb = wr_pulse;
    c_d.cmd_stb = cmd_pulse;
    c_d.push_stb = push_pulse;
    if (wr_pulse) begin
      c_d.reg_wr_addr = k_q.wr_addr;
      c_d.reg_wr_data = k_q.wr_data;
      if (k_q.wr_addr == `SPX_OPCTL_ADDR) begin
        c_d.en = k_q.wr_data[`SPX_EN_BIT];
      end
      if (k_q.wr_addr == `SPX_IOCFG2_ADDR) begin
        c_d.pda = k_q.wr_data[`SPX_PDA_BIT];
        c_d.pdb = k_q.wr_data[`SPX_PDB_BIT];
      end
    end
    if (push_pulse) begin
      c_d.push_data = k_q.push_data;
    end
    c_d.fifo_ok = c_q.en & osc_stable;
    // the pull-down lags the output enable by the two sync stages and its own flop
    c_d.pd_en = c_q.pda & c_q.pdb & ~c_q.oe_s2;
    // a new frame clears the request; a finish in that cycle wins
    if (!c_q.ssn_s2 && c_q.ssn_s3) begin
      c_d.irq = 1'b0;
    end
    if (cmd_pulse) begin
      c_d.cmd_code = k_q.cmd_code;
      if (is_long(k_q.cmd_code)) begin
        c_d.busy = 1'b1;
      end
    end
    if (c_q.busy && proc_done) begin
      c_d.busy = 1'b0;
      c_d.irq = 1'b1;
    end
  end

  // sync reset; chip select sync idles high
  always_ff @(posedge mclk) begin
    if (rst) begin
      c_q <= '0;
      c_q.ssn_s1 <= 1'b1;
      c_q.ssn_s2 <= 1'b1;
      c_q.ssn_s3 <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign sdo = t_q.sdo;
  assign sdo_oe = t_q.oe;
  assign sdo_pd_en = c_q.pd_en;
  assign irq = c_q.irq;
  assign reg_wr_stb = c_q.reg_wr_stb;
  assign reg_wr_addr = c_q.reg_wr_addr;
  assign reg_wr_data = c_q.reg_wr_data;
  assign cmd_stb = c_q.cmd_stb;
  assign cmd_code = c_q.cmd_code;
  assign fifo_push_stb = c_q.push_stb;
  assign fifo_push_data = c_q.push_data;

endmodule
`default_nettype wire

/* spx_port_chk.sv */
// concurrent checks on the serial command port's pins
`timescale 1ns/1ps
`default_nettype none
`include "spx_cfg.svh"
module spx_port_chk (
  // clocks and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  // link pins
  input wire logic ss_n,
  input wire logic sdo_oe,
  input wire logic sdo_pd_en,
  // status and strobes
  input wire logic proc_done,
  input wire logic irq,
  input wire logic reg_wr_stb,
  input wire logic [5:0] reg_wr_addr,
  input wire logic cmd_stb,
  input wire logic fifo_push_stb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // link output stage
  // ----------------------------------------------------------------
  AST_OE_DESEL: assert property (ss_n |-> !sdo_oe)
    else $error("data out driven while deselected");
  AST_OE_HOLD: assert property (sdo_oe && !ss_n |=> sdo_oe || ss_n)
    else $error("data out released inside a frame");
  // sync latency lets the pull-down overlap for three cycles only
  AST_PD_OFF: assert property (sdo_oe [*4] |-> !sdo_pd_en)
    else $error("pull-down on while data out driven");

  // ----------------------------------------------------------------
  // core-side strobes and interrupt
  // ----------------------------------------------------------------
  AST_WR_ONE: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe longer than one cycle");
  AST_WR_MAP: assert property (
    reg_wr_stb |-> reg_wr_addr <= `SPX_RW_TOP)
    else $error("write strobe outside writable range");
  AST_CMD_ONE: assert property (cmd_stb |=> !cmd_stb)
    else $error("command strobe longer than one cycle");
  AST_PUSH_ONE: assert property (fifo_push_stb |=> !fifo_push_stb)
    else $error("push strobe longer than one cycle");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(proc_done))
    else $error("interrupt without finished process");
  AST_IRQ_HOLD: assert property (irq && ss_n |=> irq)
    else $error("interrupt dropped while deselected");
  AST_RST_QUIET: assert property (
    $fell(rst) |-> !(irq || reg_wr_stb || cmd_stb || fifo_push_stb))
    else $error("output active out of reset");

  // main scenarios seen
  cover property (reg_wr_stb);
  cover property (fifo_push_stb);
  cover property ($rose(irq));
  cover property (@(posedge sclk) sdo_oe);
endmodule
`default_nettype wire

/* test_spx_port.sv */
// self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
module test_spx_port import spx_pkg::*;;
  logic mclk, rst, osc_stable, proc_done;
  logic sclk, ss_n, sdi, sdo, sdo_oe, sdo_pd_en, irq;
  logic reg_wr_stb, cmd_stb, fifo_push_stb;
  logic [5:0] reg_wr_addr, cmd_code;
  logic [7:0] reg_wr_data, fifo_push_data, rx;
  logic [7:0] rq[$], pq[$], ev[3];
  logic [13:0] wq[$];
  logic [5:0] cq[$];
  int fails = 0;
  int n_checks = 0;

  spx_port i_spx_port (.mclk(mclk), .rst(rst), .sclk(sclk), .ss_n(ss_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sdo_pd_en(sdo_pd_en),
    .osc_stable(osc_stable), .proc_done(proc_done), .irq(irq),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .cmd_stb(cmd_stb), .cmd_code(cmd_code),
    .fifo_push_stb(fifo_push_stb), .fifo_push_data(fifo_push_data));
  spx_master i_spx_master (.sclk(sclk), .ss_n(ss_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .sdo_pd_en(sdo_pd_en));

  // 40 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // collect strobes away from the edge that launches them
  always @(negedge mclk) begin
    if (reg_wr_stb === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
    if (cmd_stb === 1'b1) cq.push_back(cmd_code);
    if (fifo_push_stb === 1'b1) pq.push_back(fifo_push_data);
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [13:0] got,
                       input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one frame of whole bytes, an optional cut byte, replies kept
  task automatic frame(input logic [7:0] bytes[$], input int tail);
    rq.delete();
    i_spx_master.sel();
    foreach (bytes[i]) begin
      i_spx_master.xfer(bytes[i], 8, rx);
      rq.push_back(rx);
    end
    if (tail > 0) i_spx_master.xfer(8'h5a, tail, rx);
    i_spx_master.desel();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    osc_stable = 1'b1;
    proc_done = 1'b0;
    ev = '{8'h11, 8'h18, 8'h80};
    // link pointers reset only with sclk running under reset
    fork
      begin
        repeat (6) @(posedge mclk);
        #1 rst <= 1'b0;
      end
      begin
        // let the model's idle-high select land first
        #1 i_spx_master.sel();
        i_spx_master.xfer(8'h00, 3, rx);
      end
    join
    i_spx_master.desel();
    // burst write from 0x00 (pull-downs, enable), read back
    frame('{8'h00, 8'h11, 8'h18, 8'h80}, 0);
    frame('{8'h40, 8'h00, 8'h00, 8'h00}, 0);
    for (int i = 0; i < 3; i++) begin
      check("wr", wq[i], {6'(i), ev[i]});
      check("rd", {6'h00, rq[i+1]}, {6'h00, ev[i]});
    end
    check("pd", {13'h0, sdo_pd_en}, 14'h1);
    // read-only, missing and cut writes all leave no trace
    frame('{8'h3f, 8'h77}, 0);
    frame('{8'h30, 8'h77}, 0);
    frame('{8'h05}, 5);
    check("n_wr", 14'(wq.size()), 14'd3);
    frame('{8'h70, 8'h00}, 0);
    check("missing", {6'h00, rq[1]}, 14'h0);
    // command chained ahead of a read
    frame('{8'hc1, 8'h42, 8'h00}, 0);
    check("cmd", {8'h00, cq[0]}, 14'h01);
    check("chain", {6'h00, rq[2]}, 14'h80);
    // fifo load; c3 must not decode as a command
    frame('{8'h80, 8'ha1, 8'hb2, 8'hc3}, 4);
    check("n_push", 14'(pq.size()), 14'd3);
    check("push", {6'h00, pq[2]}, 14'hc3);
    check("n_cmd", 14'(cq.size()), 14'd1);
    frame('{8'h7f, 8'h00}, 0);
    check("count", {6'h00, rq[1]}, 14'h03);
    // fifo read cut in mid-byte, then resumed
    frame('{8'hbf, 8'h00}, 4);
    check("fifo", {6'h00, rq[1]}, 14'ha1);
    frame('{8'hbf, 8'h00, 8'h00}, 0);
    check("unread", {6'h00, rq[1]}, 14'hb2);
    check("next", {6'h00, rq[2]}, 14'hc3);
    // empty fifo sends zero; an odd trailer is ignored whole
    frame('{8'hbf, 8'h00}, 0);
    check("empty", {6'h00, rq[1]}, 14'h0);
    frame('{8'h85, 8'h77}, 0);
    check("odd", 14'(pq.size()), 14'd3);
    frame('{8'h7f, 8'h00}, 0);
    check("drained", {6'h00, rq[1]}, 14'h0);
    // fifo refused while the oscillator is unsettled
    @(posedge mclk);
    #1 osc_stable <= 1'b0;
    frame('{8'h80, 8'hee}, 0);
    check("refused", 14'(pq.size()), 14'd3);
    @(posedge mclk);
    #1 osc_stable <= 1'b1;
    // lengthy command; link stays quiet until the interrupt
    frame('{8'hf8}, 0);
    @(posedge mclk);
    #1 proc_done <= 1'b1;
    @(posedge mclk);
    #1 proc_done <= 1'b0;
    repeat (3) @(posedge mclk);
    check("irq", {13'h0, irq}, 14'h1);
    #1 i_spx_master.sel();
    repeat (6) @(posedge mclk);
    check("irq_clr", {13'h0, irq}, 14'h0);
    i_spx_master.desel();
    give_verdict();
  end
  // watchdog: the sequence needs well under 40 us
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule

bind spx_port spx_port_chk i_spx_port_chk (.mclk(mclk), .rst(rst),
  .sclk(sclk), .ss_n(ss_n), .sdo_oe(sdo_oe), .sdo_pd_en(sdo_pd_en),
  .proc_done(proc_done), .irq(irq), .reg_wr_stb(reg_wr_stb),
  .reg_wr_addr(reg_wr_addr), .cmd_stb(cmd_stb),
  .fifo_push_stb(fifo_push_stb));
`default_nettype wire
